//--- sid_input_logic.sv
// sid_input_logic.sv: discrete input interpretation for the servo amplifier
// assumes raw 24 V inputs already level-shifted to logic; 1 means contact on
//
// Notes on behaviour
// (RULE1) decel-type stop off: commanded deceleration to stop
// (RULE2) decel-type stop back on leaves stop
// (RULE3) only one stop input type used, by config
// (RULE4) torque mode: decel-type acts as shutoff-type
// (RULE5) usage digit 1 ignores both stop inputs
// (RULE6) method 0: brake interlock drops immediately
// (RULE7) method 2: brake interlock drops after deceleration
// (RULE8) shutoff-type off: base off, dynamic brake on
// (RULE9) shutoff-type back on releases stop
// (RULE10) each direction permitted only while its stroke-end on
// (RULE11) stroke-end off: stop and servo-lock; code locks only while a move toward that end is requested
// (RULE12) proportional input selects pure proportional speed loop
// (RULE13) controller should avoid proportional input in torque mode
// (RULE14) gain input a selects first alternate set
// (RULE15) gain input b selects second alternate set
// (RULE16) both gain inputs: second set wins
// (RULE17) dog detect polarity follows dog polarity setting
// (RULE18) loop select picks semi/fully closed when enabled
// (RULE19) probe input rising latches current position; with rises in one cycle only the lowest channel is stored
// (RULE20) general pins mapped by assignment; stop pin fixed
// (RULE21) all inputs synchronised and debounced first
`timescale 1ns/10ps
`default_nettype none
`include "sid_consts.svh"
module sid_input_logic
    import sid_pkg::*;
#(
    parameter int DEB_CYC = `SID_DEB_CYC,
    parameter int POS_W   = `SID_POS_W
) (
    // clock and reset
    input  wire logic             sys_clk_in,
    input  wire logic             rst_b_in,
    // fixed forced stop pins
    input  wire logic             decel_forced_stop_in,
    input  wire logic             shutoff_forced_stop_in,
    // assignable general pins
    input  wire logic [4:0]       gp_pin_in,
    // configuration
    input  wire logic [1:0]       stop_method_digit_in,
    input  wire logic             forced_stop_usage_digit_in,
    input  wire logic             dog_polarity_setting_in,
    input  wire logic             loop_switch_enable_setting_in,
    input  wire logic             assign_load_in,
    input  wire logic [3:0]       input_assign_a_in,
    input  wire logic [3:0]       input_assign_b_in,
    input  wire logic [3:0]       input_assign_c_in,
    input  wire logic [3:0]       input_assign_d_in,
    input  wire logic [3:0]       input_assign_e_in,
    // drive status
    input  wire logic             torque_mode_in,
    input  wire logic             servo_on_in,
    input  wire logic             alarm_in,
    input  wire logic             decel_done_in,
    input  wire logic             move_pos_req_in,
    input  wire logic             move_neg_req_in,
    input  wire logic [POS_W-1:0] position_in,
    // probe readout
    input  wire logic [1:0]       probe_rd_sel_in,
    input  wire logic [2:0]       probe_clr_in,
    // actions
    output logic                  decel_cmd_out,
    output logic                  base_shutoff_out,
    output logic                  dyn_brake_out,
    output logic                  brake_interlock_out,
    output logic                  fwd_permit_out,
    output logic                  rev_permit_out,
    output logic                  servo_lock_out,
    output logic                  prop_mode_out,
    output logic [1:0]            gain_set_out,
    output logic                  dog_detect_out,
    output logic                  full_closed_out,
    output logic [2:0]            probe_flag_out,
    output logic [POS_W-1:0]      probe_pos_out
);
    localparam int NIN = 7;
    localparam logic [`SID_CNT_W-1:0] DEB_LAST = `SID_CNT_W'(DEB_CYC - 1);

    // input conditioning: two-flop sync then stable-count filter
    logic [NIN-1:0] raw;
    logic [NIN-1:0] sync1_r;
    logic [NIN-1:0] sync2_r;
    logic [NIN-1:0] filt_r;
    logic [NIN-1:0] filt_nxt;
    logic [NIN-1:0] filt_d_r;
    logic [`SID_CNT_W-1:0] cnt_r   [NIN];
    logic [`SID_CNT_W-1:0] cnt_nxt [NIN];

    assign raw = {shutoff_forced_stop_in, decel_forced_stop_in, gp_pin_in};

    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_deb
            always_comb begin
                filt_nxt[gi] = filt_r[gi];
                cnt_nxt[gi]  = '0;
                if (sync2_r[gi] != filt_r[gi]) begin
                    if (cnt_r[gi] >= DEB_LAST) begin
                        filt_nxt[gi] = sync2_r[gi]; // [RULE21]
                    end else begin
                        cnt_nxt[gi] = cnt_r[gi] + `SID_CNT_W'(1);
                    end
                end
            end

            always_ff @(posedge sys_clk_in) begin
                if (!rst_b_in) begin
                    sync1_r[gi]  <= 1'b0;
                    sync2_r[gi]  <= 1'b0;
                    filt_r[gi]   <= 1'b0;
                    filt_d_r[gi] <= 1'b0;
                    cnt_r[gi]    <= '0;
                end else begin
                    sync1_r[gi]  <= raw[gi];
                    sync2_r[gi]  <= sync1_r[gi]; // [RULE21]
                    filt_r[gi]   <= filt_nxt[gi];
                    filt_d_r[gi] <= filt_r[gi];
                    cnt_r[gi]    <= cnt_nxt[gi];
                end
            end
        end
    endgenerate

    // pin assignment table; reset gives the stroke ends and the dog
    logic [3:0] asg_r   [`SID_NUM_GP];
    logic [3:0] asg_nxt [`SID_NUM_GP];

    always_comb begin
        for (int i = 0; i < `SID_NUM_GP; i++) begin
            asg_nxt[i] = asg_r[i];
        end
        if (assign_load_in) begin
            asg_nxt[0] = input_assign_a_in; // [RULE20]
            asg_nxt[1] = input_assign_b_in;
            asg_nxt[2] = input_assign_c_in;
            asg_nxt[3] = input_assign_d_in;
            asg_nxt[4] = input_assign_e_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            asg_r[0] <= `SID_ASSIGN_A_RST; // [RULE20]
            asg_r[1] <= `SID_ASSIGN_B_RST;
            asg_r[2] <= `SID_ASSIGN_C_RST;
            asg_r[3] <= `SID_ASSIGN_D_RST;
            asg_r[4] <= `SID_ASSIGN_E_RST;
        end else begin
            for (int i = 0; i < `SID_NUM_GP; i++) begin
                asg_r[i] <= asg_nxt[i];
            end
        end
    end

    // level of a function: or over every pin assigned to it.
    // probes may only sit on the last two pins, others decode as unused
    function automatic logic func_level(input logic [4:0] lvl,
                                        input logic [19:0] codes,
                                        input sid_func_type fn);
        logic hit;
        hit = 1'b0;
        for (int p = 0; p < `SID_NUM_GP; p++) begin
            if (codes[p*4 +: 4] == fn && (fn < SID_FN_PR1 || p >= 3)) begin
                hit = hit | lvl[p];
            end
        end
        return hit;
    endfunction

    logic [19:0] codes;
    logic [4:0]  gp_lvl;
    logic [4:0]  gp_prev;
    logic        fwd_stroke_end;
    logic        rev_stroke_end;
    logic        dog_level;
    logic        prop_ctrl;
    logic        gain_sel_a;
    logic        gain_sel_b;
    logic        loop_select;
    logic [2:0]  probe_now;
    logic [2:0]  probe_was;

    assign codes   = {asg_r[4], asg_r[3], asg_r[2], asg_r[1], asg_r[0]};
    assign gp_lvl  = filt_r[4:0];
    assign gp_prev = filt_d_r[4:0];

    assign fwd_stroke_end = func_level(gp_lvl, codes, SID_FN_FWD); // [RULE20]
    assign rev_stroke_end = func_level(gp_lvl, codes, SID_FN_REV);
    assign dog_level      = func_level(gp_lvl, codes, SID_FN_DOG);
    assign prop_ctrl      = func_level(gp_lvl, codes, SID_FN_PROP);
    assign gain_sel_a     = func_level(gp_lvl, codes, SID_FN_GAIN_A);
    assign gain_sel_b     = func_level(gp_lvl, codes, SID_FN_GAIN_B);
    assign loop_select    = func_level(gp_lvl, codes, SID_FN_LOOP);
    assign probe_now[0]   = func_level(gp_lvl, codes, SID_FN_PR1);
    assign probe_now[1]   = func_level(gp_lvl, codes, SID_FN_PR2);
    assign probe_now[2]   = func_level(gp_lvl, codes, SID_FN_PR3);
    assign probe_was[0]   = func_level(gp_prev, codes, SID_FN_PR1);
    assign probe_was[1]   = func_level(gp_prev, codes, SID_FN_PR2);
    assign probe_was[2]   = func_level(gp_prev, codes, SID_FN_PR3);

    // forced stop: the stop method digit picks which pin is live
    logic use_decel_pin;
    logic stop_req;
    logic soft_stop;

    always_comb begin
        use_decel_pin = (stop_method_digit_in == `SID_STOP_DECEL); // [RULE3]
        stop_req      = 1'b0;
        if (forced_stop_usage_digit_in == `SID_USAGE_ON) begin // [RULE5]
            stop_req = use_decel_pin ? !filt_r[5] : !filt_r[6]; // [RULE1] [RULE8]
        end
        // torque mode turns a decel-type stop into a shutoff stop
        soft_stop = use_decel_pin && !torque_mode_in; // [RULE4]
    end

    // stop sequencing
    sid_state_type st_r;
    sid_state_type st_nxt;

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            SID_ST_RUN: begin
                if (stop_req || alarm_in) begin
                    st_nxt = soft_stop ? SID_ST_DECEL : SID_ST_SHUT; // [RULE1] [RULE8] [RULE6]
                end
            end
            SID_ST_DECEL: begin
                if (!stop_req && !alarm_in) begin
                    st_nxt = SID_ST_RUN; // [RULE2]
                end else if (!soft_stop || decel_done_in) begin
                    st_nxt = SID_ST_SHUT; // [RULE7]
                end
            end
            SID_ST_SHUT: begin
                if (!stop_req && !alarm_in) begin
                    st_nxt = SID_ST_RUN; // [RULE9] [RULE2]
                end
            end
            default: begin
                st_nxt = SID_ST_SHUT;
            end
        endcase
    end

    // registered outputs
    logic             decel_nxt;
    logic             shut_nxt;
    logic             brake_nxt;
    logic             fwd_nxt;
    logic             rev_nxt;
    logic             lock_nxt;
    logic             prop_nxt;
    logic [1:0]       gain_nxt;
    logic             dog_nxt;
    logic             closed_nxt;
    logic [2:0]       pflag_nxt;
    logic [2:0]       prise;
    logic             pwr_en;
    logic [1:0]       pwr_addr;

    always_comb begin
        decel_nxt  = (st_nxt == SID_ST_DECEL); // [RULE1]
        shut_nxt   = (st_nxt == SID_ST_SHUT); // [RULE8]
        // brake stays released through deceleration, drops on shutoff
        brake_nxt  = servo_on_in && (st_nxt != SID_ST_SHUT); // [RULE6] [RULE7]
        fwd_nxt    = fwd_stroke_end; // [RULE10]
        rev_nxt    = rev_stroke_end; // [RULE10]
        lock_nxt   = (move_pos_req_in && !fwd_stroke_end)
                   || (move_neg_req_in && !rev_stroke_end); // [RULE11]
        prop_nxt   = prop_ctrl; // [RULE12]
        gain_nxt   = gain_sel_b ? 2'h2 : (gain_sel_a ? 2'h1 : 2'h0); // [RULE14] [RULE15] [RULE16]
        dog_nxt    = dog_polarity_setting_in ? !dog_level : dog_level; // [RULE17]
        closed_nxt = loop_switch_enable_setting_in && loop_select; // [RULE18]
        prise      = probe_now & ~probe_was;
        // a new latch wins over a clear arriving in the same cycle
        pflag_nxt  = (probe_flag_out & ~probe_clr_in) | prise;
        pwr_en     = |prise; // [RULE19]
        // simultaneous edges: only the lowest channel stored, others lost
        pwr_addr   = prise[0] ? 2'h0 : (prise[1] ? 2'h1 : 2'h2);
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            st_r                <= SID_ST_SHUT;
            decel_cmd_out       <= 1'b0;
            base_shutoff_out    <= 1'b1;
            dyn_brake_out       <= 1'b1;
            brake_interlock_out <= 1'b0;
            fwd_permit_out      <= 1'b0;
            rev_permit_out      <= 1'b0;
            servo_lock_out      <= 1'b0;
            prop_mode_out       <= 1'b0;
            gain_set_out        <= 2'h0;
            dog_detect_out      <= 1'b0;
            full_closed_out     <= 1'b0;
            probe_flag_out      <= 3'h0;
        end else begin
            st_r                <= st_nxt;
            decel_cmd_out       <= decel_nxt;
            base_shutoff_out    <= shut_nxt;
            dyn_brake_out       <= shut_nxt;
            brake_interlock_out <= brake_nxt;
            fwd_permit_out      <= fwd_nxt;
            rev_permit_out      <= rev_nxt;
            servo_lock_out      <= lock_nxt;
            prop_mode_out       <= prop_nxt;
            gain_set_out        <= gain_nxt;
            dog_detect_out      <= dog_nxt;
            full_closed_out     <= closed_nxt;
            probe_flag_out      <= pflag_nxt;
        end
    end

    sid_probe_mem #(
        .DEPTH (`SID_NUM_PROBE),
        .WIDTH (POS_W),
        .AW    (2)
    ) u_probe_mem (
        .sys_clk_in  (sys_clk_in),
        .rst_b_in    (rst_b_in),
        .wr_en_in    (pwr_en),
        .wr_addr_in  (pwr_addr),
        .wr_data_in  (position_in), // [RULE19]
        .rd_addr_in  (probe_rd_sel_in),
        .rd_data_out (probe_pos_out)
    );
endmodule // sid_input_logic
`default_nettype wire

//--- sid_consts.svh
// sid_consts.svh: offsets-free constant set for the servo input-device logic
// assumes inclusion by bare name from the package and the top module
`ifndef SID_CONSTS_SVH
`define SID_CONSTS_SVH

`define SID_CLK_PERIOD_NS  10
`define SID_DEB_TIME_NS    10000
`define SID_DEB_CYC        ((`SID_DEB_TIME_NS + `SID_CLK_PERIOD_NS - 1) / `SID_CLK_PERIOD_NS)
`define SID_CNT_W          12
`define SID_POS_W          32
`define SID_NUM_GP         5
`define SID_NUM_PROBE      3

`define SID_STOP_IMMEDIATE 2'h0
`define SID_STOP_DECEL     2'h2
`define SID_USAGE_ON       1'h0
`define SID_USAGE_OFF      1'h1

`define SID_ASSIGN_A_RST   4'h1
`define SID_ASSIGN_B_RST   4'h2
`define SID_ASSIGN_C_RST   4'h3
`define SID_ASSIGN_D_RST   4'h0
`define SID_ASSIGN_E_RST   4'h0

`endif

//--- sid_pkg.sv
// sid_pkg.sv: types shared by the servo input-device logic
// assumes sid_consts.svh on the include path
package sid_pkg;
    `include "sid_consts.svh"

    typedef enum logic [1:0] {
        SID_ST_RUN   = 2'b00,
        SID_ST_DECEL = 2'b01,
        SID_ST_SHUT  = 2'b10
    } sid_state_type;

    typedef enum logic [3:0] {
        SID_FN_NONE   = 4'b0000,
        SID_FN_FWD    = 4'b0001,
        SID_FN_REV    = 4'b0010,
        SID_FN_DOG    = 4'b0011,
        SID_FN_PROP   = 4'b0100,
        SID_FN_GAIN_A = 4'b0101,
        SID_FN_GAIN_B = 4'b0110,
        SID_FN_LOOP   = 4'b0111,
        SID_FN_PR1    = 4'b1000,
        SID_FN_PR2    = 4'b1001,
        SID_FN_PR3    = 4'b1010
    } sid_func_type;
endpackage

//--- sid_probe_mem.sv
// sid_probe_mem.sv: latched touch-probe positions, one word per channel
// assumes one write per cycle at most; read data is registered
`timescale 1ns/10ps
`default_nettype none
module sid_probe_mem #(
    parameter int DEPTH = 3,
    parameter int WIDTH = 32,
    parameter int AW    = 2
) (
    // clock and reset
    input  wire logic             sys_clk_in,
    input  wire logic             rst_b_in,
    // write port
    input  wire logic             wr_en_in,
    input  wire logic [AW-1:0]    wr_addr_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    // read port
    input  wire logic [AW-1:0]    rd_addr_in,
    output logic      [WIDTH-1:0] rd_data_out
);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [WIDTH-1:0] rd_nxt;

    always_comb begin
        rd_nxt = '0;
        if (int'(rd_addr_in) < DEPTH) begin
            rd_nxt = mem_r[rd_addr_in];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            rd_data_out <= '0;
        end else begin
            rd_data_out <= rd_nxt;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (wr_en_in && int'(wr_addr_in) < DEPTH) begin
            mem_r[wr_addr_in] <= wr_data_in;
        end
    end
endmodule // sid_probe_mem
`default_nettype wire

//--- sid_input_logic_chk.sv
// sid_input_logic_chk.sv: port-level assertions for the input-device logic
// assumes it is bound onto sid_input_logic, one clock domain
`timescale 1ns/10ps
`default_nettype none
module sid_input_logic_chk #(
    parameter int DEB_CYC = 4
) (
    // clock and reset
    input wire logic       sys_clk_in,
    input wire logic       rst_b_in,
    // inputs of the block
    input wire logic       shutoff_forced_stop_in,
    input wire logic [1:0] stop_method_digit_in,
    input wire logic       torque_mode_in,
    input wire logic       alarm_in,
    input wire logic       decel_done_in,
    input wire logic [2:0] probe_clr_in,
    // outputs of the block
    input wire logic       decel_cmd_out,
    input wire logic       base_shutoff_out,
    input wire logic       dyn_brake_out,
    input wire logic       brake_interlock_out,
    input wire logic [1:0] gain_set_out,
    input wire logic [2:0] probe_flag_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);

    chk_shut_dyn_pair: assert property (base_shutoff_out == dyn_brake_out)
        else $error("dynamic brake differs from base shutoff");
    chk_shut_brake_low: assert property (base_shutoff_out |-> !brake_interlock_out)
        else $error("brake released while base is shut off");
    chk_decel_not_shut: assert property (decel_cmd_out |-> !base_shutoff_out)
        else $error("deceleration and shutoff at once");
    chk_decel_then_drop: assert property (decel_cmd_out && decel_done_in |=>
        base_shutoff_out && !decel_cmd_out && !brake_interlock_out)
        else $error("brake not dropped after deceleration");
    chk_alarm_drop_now: assert property ($rose(alarm_in) && stop_method_digit_in == 2'h0 |->
        ##[1:3] (base_shutoff_out && !brake_interlock_out && !decel_cmd_out))
        else $error("alarm did not drop brake at once");
    chk_alarm_decel_first: assert property ($rose(alarm_in) && stop_method_digit_in == 2'h2
        && !torque_mode_in && !base_shutoff_out |-> ##[1:3] decel_cmd_out)
        else $error("alarm did not start deceleration");
    chk_gain_code_legal: assert property (gain_set_out != 2'h3)
        else $error("gain set code out of range");
    chk_glitch_no_shut: assert property ($fell(shutoff_forced_stop_in) && !alarm_in
        && !base_shutoff_out && !decel_cmd_out |=> !base_shutoff_out)
        else $error("stop pin acted without filtering");
    // a flag may only fall one or two cycles after its clear pulse
    chk_probe_flag_hold: assert property (((~probe_flag_out) & $past(probe_flag_out)
        & ~$past(probe_clr_in) & ~$past(probe_clr_in, 2)) == 3'h0)
        else $error("probe flag lost without clear");
endmodule // sid_input_logic_chk
bind sid_input_logic sid_input_logic_chk #(.DEB_CYC(DEB_CYC)) u_chk (.sys_clk_in, .rst_b_in,
    .shutoff_forced_stop_in, .stop_method_digit_in, .torque_mode_in, .alarm_in, .decel_done_in,
    .probe_clr_in, .decel_cmd_out, .base_shutoff_out, .dyn_brake_out, .brake_interlock_out,
    .gain_set_out, .probe_flag_out);
`default_nettype wire

//--- sid_far_side.sv
// sid_far_side.sv: motion controller answering commanded deceleration
// assumes decel_cmd_in comes from the block, same clock
`timescale 1ns/10ps
`default_nettype none
module sid_far_side (
    // clock and reset
    input  wire logic sys_clk_in,
    input  wire logic rst_b_in,
    // deceleration handshake
    input  wire logic slow_in,
    input  wire logic decel_cmd_in,
    output logic      decel_done_out
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    always_comb begin
        cnt_nxt = decel_cmd_in ? cnt_r + 8'h01 : 8'h00;
    end
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in)
            cnt_r <= 8'h00;
        else
            cnt_r <= cnt_nxt;
    end
    // slow mode keeps the ramp long enough to observe it from outside
    assign decel_done_out = decel_cmd_in && (cnt_r >= (slow_in ? 8'h18 : 8'h02));
endmodule // sid_far_side
`default_nettype wire

//--- sid_tb.sv
// sid_tb.sv: self-checking bench for the input-device logic
// assumes a filter length of 4 so a pin change shows within 12 cycles
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic sys_clk_in, rst_b_in, decel_forced_stop_in, shutoff_forced_stop_in, forced_stop_usage_digit_in;
    logic dog_polarity_setting_in, loop_switch_enable_setting_in, assign_load_in, torque_mode_in, slow;
    logic servo_on_in, alarm_in, decel_done_in, move_pos_req_in, move_neg_req_in;
    logic decel_cmd_out, base_shutoff_out, dyn_brake_out, brake_interlock_out, fwd_permit_out;
    logic rev_permit_out, servo_lock_out, prop_mode_out, dog_detect_out, full_closed_out;
    logic [4:0]  gp_pin_in;
    logic [1:0]  stop_method_digit_in, probe_rd_sel_in, gain_set_out;
    logic [3:0]  input_assign_a_in, input_assign_b_in, input_assign_c_in, input_assign_d_in, input_assign_e_in;
    logic [2:0]  probe_clr_in, probe_flag_out;
    logic [31:0] position_in, probe_pos_out;
    int          err_total, comparisons, cyc;

    sid_input_logic #(.DEB_CYC(4)) DUT (.sys_clk_in, .rst_b_in, .decel_forced_stop_in,
        .shutoff_forced_stop_in, .gp_pin_in, .stop_method_digit_in, .forced_stop_usage_digit_in,
        .dog_polarity_setting_in, .loop_switch_enable_setting_in, .assign_load_in, .input_assign_a_in,
        .input_assign_b_in, .input_assign_c_in, .input_assign_d_in, .input_assign_e_in, .torque_mode_in,
        .servo_on_in, .alarm_in, .decel_done_in, .move_pos_req_in, .move_neg_req_in, .position_in,
        .probe_rd_sel_in, .probe_clr_in, .decel_cmd_out, .base_shutoff_out, .dyn_brake_out,
        .brake_interlock_out, .fwd_permit_out, .rev_permit_out, .servo_lock_out, .prop_mode_out,
        .gain_set_out, .dog_detect_out, .full_closed_out, .probe_flag_out, .probe_pos_out);
    sid_far_side u_far (.sys_clk_in, .rst_b_in, .slow_in(slow), .decel_cmd_in(decel_cmd_out),
        .decel_done_out(decel_done_in));

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // order: decel, shutoff, dynamic brake, brake released
    task automatic stop_is(input logic [3:0] e);
        chk("stop", {28'h0, e}, {28'h0, decel_cmd_out, base_shutoff_out, dyn_brake_out, brake_interlock_out});
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask
    task automatic load_map(input logic [19:0] m);
        {input_assign_e_in, input_assign_d_in, input_assign_c_in, input_assign_b_in, input_assign_a_in} <= m;
        assign_load_in <= 1'b1;
        wt(1);
        assign_load_in <= 1'b0;
        wt(1);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            print_verdict;
        end
    end

    initial begin
        int i;
        {decel_forced_stop_in, shutoff_forced_stop_in, gp_pin_in} = 7'h7f;
        {forced_stop_usage_digit_in, dog_polarity_setting_in, loop_switch_enable_setting_in} = 3'h0;
        {assign_load_in, torque_mode_in, alarm_in, move_pos_req_in, move_neg_req_in} = 5'h0;
        {rst_b_in, servo_on_in, slow, stop_method_digit_in, probe_rd_sel_in, probe_clr_in} = 10'h1c0;
        {input_assign_e_in, input_assign_d_in, input_assign_c_in, input_assign_b_in, input_assign_a_in} = 20'h00321;
        position_in = 32'h0;
        wt(20);
        stop_is(4'h6);
        rst_b_in <= 1'b1;
        wt(12);
        stop_is(4'h1);
        decel_forced_stop_in <= 1'b0;
        wt(12);
        stop_is(4'h9);
        wt(30);
        stop_is(4'h6);
        decel_forced_stop_in <= 1'b1;
        shutoff_forced_stop_in <= 1'b0;
        wt(12);
        stop_is(4'h1);
        shutoff_forced_stop_in <= 1'b1;
        stop_method_digit_in <= 2'h0;
        decel_forced_stop_in <= 1'b0;
        wt(12);
        stop_is(4'h1);
        decel_forced_stop_in <= 1'b1;
        shutoff_forced_stop_in <= 1'b0;
        wt(2);
        shutoff_forced_stop_in <= 1'b1;
        wt(12);
        stop_is(4'h1);
        shutoff_forced_stop_in <= 1'b0;
        wt(12);
        stop_is(4'h6);
        shutoff_forced_stop_in <= 1'b1;
        wt(12);
        stop_is(4'h1);
        // servo off holds the brake even while running
        servo_on_in <= 1'b0;
        wt(3);
        stop_is(4'h0);
        servo_on_in <= 1'b1;
        // alarm under both stop methods
        for (i = 0; i < 2; i++) begin
            stop_method_digit_in <= i[0] ? 2'h2 : 2'h0;
            alarm_in <= 1'b1;
            wt(3);
            stop_is(i[0] ? 4'h9 : 4'h6);
            wt(30);
            stop_is(4'h6);
            alarm_in <= 1'b0;
            wt(3);
            stop_is(4'h1);
        end
        slow <= 1'b0;
        forced_stop_usage_digit_in <= 1'b1;
        {decel_forced_stop_in, shutoff_forced_stop_in} <= 2'h0;
        wt(12);
        stop_is(4'h1);
        forced_stop_usage_digit_in <= 1'b0;
        wt(12);
        stop_is(4'h6);
        {decel_forced_stop_in, shutoff_forced_stop_in} <= 2'h3;
        torque_mode_in <= 1'b1;
        wt(12);
        decel_forced_stop_in <= 1'b0;
        wt(12);
        stop_is(4'h6);
        decel_forced_stop_in <= 1'b1;
        torque_mode_in <= 1'b0;
        {move_pos_req_in, move_neg_req_in} <= 2'h3;
        for (i = 0; i < 4; i++) begin
            gp_pin_in <= {3'h0, i[1:0]};
            wt(12);
            chk("stroke", {29'h0, i[0], i[1], i != 3}, {29'h0, fwd_permit_out, rev_permit_out, servo_lock_out});
        end
        for (i = 0; i < 4; i++) begin
            dog_polarity_setting_in <= i[1];
            gp_pin_in <= {2'h0, i[0], 2'h3};
            wt(12);
            chk("dog", {31'h0, i[0] ^ i[1]}, {31'h0, dog_detect_out});
        end
        gp_pin_in <= 5'h0;
        load_map(20'h98654);
        // proportional input only with torque mode off
        for (i = 0; i < 8; i++) begin
            gp_pin_in <= {2'h0, i[2:0]};
            wt(12);
            chk("prop_gain", {29'h0, i[0], i[2] ? 2'h2 : {1'b0, i[1]}}, {29'h0, prop_mode_out, gain_set_out});
        end
        gp_pin_in <= 5'h0;
        position_in <= 32'h1234_5678;
        wt(12);
        gp_pin_in <= 5'h08;
        wt(12);
        position_in <= 32'h89ab_cdef;
        gp_pin_in <= 5'h18;
        wt(12);
        chk("flags", 32'h3, {29'h0, probe_flag_out});
        wt(2);
        chk("pos0", 32'h1234_5678, probe_pos_out);
        probe_rd_sel_in <= 2'h1;
        wt(2);
        chk("pos1", 32'h89ab_cdef, probe_pos_out);
        probe_clr_in <= 3'h3;
        wt(1);
        probe_clr_in <= 3'h0;
        gp_pin_in <= 5'h0;
        wt(12);
        chk("flags", 32'h0, {29'h0, probe_flag_out});
        load_map(20'h0a873);
        gp_pin_in <= 5'h0c;
        wt(12);
        chk("flags", 32'h4, {29'h0, probe_flag_out});
        probe_rd_sel_in <= 2'h2;
        wt(2);
        chk("pos2", 32'h89ab_cdef, probe_pos_out);
        for (i = 0; i < 4; i++) begin
            loop_switch_enable_setting_in <= i[1];
            gp_pin_in <= {3'h0, i[0], 1'b0};
            wt(12);
            chk("loop", {31'h0, i[0] & i[1]}, {31'h0, full_closed_out});
        end
        print_verdict;
    end
endmodule // tb
`default_nettype wire
